// File: dv/pcs_card_model.sv
// model of the card seated in the socket
// assumes pins change after the core clock edge; empty pins pull high
module pcs_card_model (
  input  wire logic       i_mclk,
  input  wire logic       i_ce_n,
  input  wire logic       i_ins,
  input  wire logic [5:0] i_wlen,
  input  wire logic       i_rdy,
  input  wire logic       i_wait_n,
  input  wire logic       i_bvd2,
  input  wire logic       i_req_n,
  output logic            o_cd1_n,
  output logic            o_cd2_n,
  output logic            o_vs1,
  output logic            o_vs2,
  output logic            o_rdy_ireq,
  output logic            o_wait_n,
  output logic            o_bvd2,
  output logic            o_inpack_creq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] wcnt;
  logic       ce_q;

  initial begin
    wcnt = 6'h00;
    ce_q = 1'b1;
  end

  // wait held for a set count after the enables fall
  always @(posedge i_mclk) begin
    ce_q <= i_ce_n;
    if (ce_q && !i_ce_n)
      wcnt <= i_wlen;
    else if (wcnt != 6'h00)
      wcnt <= wcnt - 6'h01;
  end

  assign o_cd1_n = !i_ins;
  assign o_cd2_n = !i_ins;
  assign o_vs1 = 1'b1;
  assign o_vs2 = !i_ins;
  assign o_rdy_ireq = !i_ins || i_rdy;
  assign o_wait_n = !i_ins || (i_wait_n && wcnt == 6'h00);
  assign o_bvd2 = !i_ins || i_bvd2;
  assign o_inpack_creq_n = !i_ins || i_req_n;
endmodule // pcs_card_model

// File: dv/pcs_socket_ctl_sva.sv
// assertions on the socket control block ports
// assumes one clock domain and the async active-low reset
module pcs_socket_ctl_sva (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_wait_n,
  input wire logic i_cd1_n,
  input wire logic i_cd2_n,
  input wire logic i_ce1_pin,
  input wire logic i_ce2_pin,
  input wire logic i_cb_cbe0_oe,
  input wire logic o_acc_busy,
  input wire logic o_acc_done,
  input wire logic o_ce1,
  input wire logic o_ce1_oe,
  input wire logic o_cb_cad10,
  input wire logic o_cb_cbe0_n,
  input wire logic o_card_rst_oe,
  input wire logic o_card_present
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] live_ff;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      live_ff <= 4'h0;
    else
      live_ff <= {live_ff[2:0], 1'b1};
  end

  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (!live_ff[3]);

  a_done_in_busy: assert property (o_acc_done |-> o_acc_busy)
    else $error("done outside busy");
  a_done_pulse: assert property (o_acc_done |=> !o_acc_done)
    else $error("done longer than one cycle");
  a_wait_holds: assert property (o_acc_done |->
    $past(i_wait_n, 2) || $past(i_wait_n, 3) || $past(i_wait_n, 4))
    else $error("cycle ended while wait held");
  a_idle_ce_off: assert property
    (!o_acc_busy && !$past(i_cb_cbe0_oe) |-> o_ce1 || !o_ce1_oe)
    else $error("enable low outside a cycle");
  a_rst_floats: assert property (o_card_rst_oe |-> o_card_present)
    else $error("reset driven without card");
  a_present_deb: assert property ($rose(o_card_present) |->
    $past(!i_cd1_n && !i_cd2_n, 3))
    else $error("presence without both detects");
  a_cad_echo: assert property (o_cb_cad10 == $past(i_ce2_pin))
    else $error("cad10 readback wrong");
  a_cbe_echo: assert property (o_cb_cbe0_n == $past(i_ce1_pin))
    else $error("cbe0 readback wrong");

  c_access: cover property (o_acc_done);
  c_insert: cover property ($rose(o_card_present));
  c_rst_drive: cover property (o_card_rst_oe);
endmodule // pcs_socket_ctl_sva

bind pcs_socket_ctl pcs_socket_ctl_sva u_pcs_socket_ctl_sva (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wait_n(i_wait_n),
  .i_cd1_n(i_cd1_n), .i_cd2_n(i_cd2_n), .i_ce1_pin(i_ce1_pin),
  .i_ce2_pin(i_ce2_pin), .i_cb_cbe0_oe(i_cb_cbe0_oe),
  .o_acc_busy(o_acc_busy), .o_acc_done(o_acc_done), .o_ce1(o_ce1),
  .o_ce1_oe(o_ce1_oe), .o_cb_cad10(o_cb_cad10),
  .o_cb_cbe0_n(o_cb_cbe0_n), .o_card_rst_oe(o_card_rst_oe),
  .o_card_present(o_card_present));

// File: dv/testbench.sv
// self-checking bench for the socket control block
// assumes the card model on the socket pins and the plain register port
module testbench import pcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr, rd, req, a0, word, cad, cad_oe;
  logic        ins, rdy, wn, bvd2, creq_n, busy, done, cad_q, cbe_q;
  logic        cbe, cbe_oe;
  logic        ce1, ce1_oe, ce2, ce2_oe, oa0, crst, crst_oe, pres;
  logic        irq, creq, serr, spkr, led, cd1_n, cd2_n, vs1, vs2;
  logic        rdy_p, wait_p, bvd2_p, req_p;
  logic [7:0]  addr;
  logic [31:0] wd, rdata, v;
  logic [5:0]  wlen;
  wire         ce1_pin = ce1_oe ? ce1 : ~ce1;
  wire         ce2_pin = ce2_oe ? ce2 : ~ce2;
  int          fail_count, n_checks, tick;

  pcs_socket_ctl #(.DEB_CYCLES(4)) u_pcs_socket_ctl (
    .i_mclk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_acc_req(req),
    .i_acc_a0(a0), .i_acc_word(word), .o_acc_busy(busy),
    .o_acc_done(done), .i_cb_cad10(cad), .i_cb_cad10_oe(cad_oe),
    .i_cb_cbe0_n(cbe), .i_cb_cbe0_oe(cbe_oe), .o_cb_cad10(cad_q),
    .o_cb_cbe0_n(cbe_q), .i_cd1_n(cd1_n), .i_cd2_n(cd2_n), .i_vs1(vs1),
    .i_vs2(vs2), .i_rdy_ireq(rdy_p), .i_wait_n(wait_p), .i_bvd2(bvd2_p),
    .i_inpack_creq_n(req_p), .i_ce1_pin(ce1_pin), .i_ce2_pin(ce2_pin),
    .o_ce1(ce1), .o_ce1_oe(ce1_oe), .o_ce2(ce2), .o_ce2_oe(ce2_oe),
    .o_a0(oa0), .o_card_rst(crst), .o_card_rst_oe(crst_oe),
    .o_card_present(pres), .o_card_irq(irq), .o_cb_req(creq),
    .o_cb_serr(serr), .o_spkr(spkr), .o_led(led));

  pcs_card_model u_pcs_card_model (
    .i_mclk(clk), .i_ce_n(ce1_pin & ce2_pin), .i_ins(ins), .i_wlen(wlen),
    .i_rdy(rdy), .i_wait_n(wn), .i_bvd2(bvd2), .i_req_n(creq_n),
    .o_cd1_n(cd1_n), .o_cd2_n(cd2_n), .o_vs1(vs1), .o_vs2(vs2),
    .o_rdy_ireq(rdy_p), .o_wait_n(wait_p), .o_bvd2(bvd2_p),
    .o_inpack_creq_n(req_p));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    tick++;
    if (tick == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task cb(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask

  task st(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task acc(input logic wv, av, input logic [1:0] e, input logic b8,
           input int lo);
    int c;
    @(posedge clk);
    req <= 1'b1;
    word <= wv;
    a0 <= av;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk("enables", 32'(e), 32'({ce1, ce2}));
    cb("busy", 1'b1, busy);
    if (b8)
      cb("addr0", av, oa0);
    c = 1;
    while (done !== 1'b1 && c < 300) begin
      @(negedge clk);
      c++;
    end
    cb("length", 1'b1,
       done === 1'b1 && (lo == 0 ? c == CMD_CYC + 2 : c > lo));
  endtask

  initial begin
    {rst_n, wr, rd, req, a0, word, cad, cad_oe, ins, cbe_oe} = 10'h000;
    {rdy, wn, bvd2, creq_n, cbe} = 5'h1F;
    addr = 8'h00;
    wd = 32'h0000_0000;
    wlen = 6'h00;
    {fail_count, n_checks, tick} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(CTRL_OFS);
    chk("ctrl", 32'(CTRL_RESET_VAL), v);
    rd_reg(MISC_OFS);
    chk("misc", 32'(MISC_RESET_VAL), v);
    rd_reg(8'h0C);
    chk("unmapped", 32'h0000_0000, v);
    cb("rst_float", 1'b0, crst_oe);
    chk("ce_oe_off", 32'h0000_0000, 32'({ce1_oe, ce2_oe}));
    @(posedge clk);
    ins <= 1'b1;
    st(20);
    cb("present", 1'b1, pres);
    rd_reg(STAT_OFS);
    chk("status", 32'h0000_1103, v & 32'h0000_1F03);
    wr_reg(STAT_OFS, 32'h0000_1000);
    rd_reg(STAT_OFS);
    cb("chg_clear", 1'b0, v[STAT_CHG_BIT]);
    wr_reg(CTRL_OFS, 32'h0000_0038);
    st(2);
    chk("rst_on", 32'h0000_0003, 32'({crst, crst_oe}));
    chk("ce_oe_on", 32'h0000_0003, 32'({ce1_oe, ce2_oe}));
    wr_reg(CTRL_OFS, 32'h0000_0034);
    st(2);
    chk("rst_off", 32'h0000_0001, 32'({crst, crst_oe}));
    acc(1'b1, 1'b0, 2'b00, 1'b0, 0);
    acc(1'b0, 1'b0, 2'b01, 1'b0, 0);
    acc(1'b0, 1'b1, 2'b10, 1'b0, 0);
    wr_reg(CTRL_OFS, 32'h0000_0030);
    acc(1'b0, 1'b1, 2'b01, 1'b1, 0);
    @(posedge clk);
    wlen <= 6'h28;
    acc(1'b0, 1'b0, 2'b01, 1'b1, 40);
    for (int m = 0; m < 3; m++) begin
      wr_reg(CTRL_OFS, 32'h0000_0030 | 32'(m));
      @(posedge clk);
      rdy <= 1'b0;
      st(6);
      cb("irq", m != 0, irq);
      rd_reg(STAT_OFS);
      if (m == 0)
        cb("ready", 1'b0, v[1]);
      @(posedge clk);
      rdy <= 1'b1;
    end
    cb("crst_cb", 1'b1, crst);
    @(posedge clk);
    creq_n <= 1'b0;
    wn <= 1'b0;
    wr_reg(MISC_OFS, 32'h0000_0010);
    st(6);
    chk("cb_pins", 32'h0000_0007, 32'({creq, serr, spkr}));
    @(posedge clk);
    creq_n <= 1'b1;
    wn <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      cad <= b[0];
      cad_oe <= 1'b1;
      cbe <= !b[0];
      cbe_oe <= 1'b1;
      st(4);
      cb("cad10", b[0], cad_q);
      cb("cbe0", !b[0], cbe_q);
    end
    wr_reg(CTRL_OFS, 32'h0000_0031);
    wr_reg(MISC_OFS, 32'h0000_0001);
    @(posedge clk);
    bvd2 <= 1'b0;
    st(6);
    cb("spkr_gated", 1'b0, spkr);
    wr_reg(MISC_OFS, 32'h0000_0011);
    st(4);
    cb("spkr_on", 1'b1, spkr);
    wr_reg(MISC_OFS, 32'h0000_0002);
    st(4);
    cb("led", 1'b1, led);
    wr_reg(MISC_OFS, 32'h0000_0000);
    wr_reg(CTRL_OFS, 32'h0000_0030);
    st(4);
    cb("led_off", 1'b0, led);
    rd_reg(STAT_OFS);
    cb("batt_warn", 1'b1, v[3]);
    final_report();
  end
endmodule // testbench

// File: verilog/pcs_pkg.sv
// package for the socket control and status signal block
// assumes one socket, a plain register port and a 250 MHz core clock
package pcs_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MISC_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;

  // control register layout
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_W16_BIT  = 2;
  localparam int CTRL_RST_BIT  = 3;
  localparam int CTRL_PWR_BIT  = 4;
  localparam int CTRL_IFEN_BIT = 5;
  localparam logic [5:0] CTRL_RESET_VAL = 6'h08;

  // misc register layout
  localparam int MISC_FN_LSB  = 0;
  localparam int MISC_SPK_BIT = 4;
  localparam logic [4:0] MISC_RESET_VAL = 5'h00;

  // status register: change flag position
  localparam int STAT_CHG_BIT = 12;

  // timing
  localparam int CLK_PS      = 4000;
  localparam int T_CMD_NS    = 100;
  localparam int T_DEB_US    = 10;
  localparam int CMD_CYC     = (T_CMD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DEB_CYC     = (T_DEB_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W       = 12;

  typedef enum logic [1:0] {
    PCS_MODE_MEM,
    PCS_MODE_IO,
    PCS_MODE_CB
  } pcs_mode_e;

  typedef enum logic [1:0] {
    PCS_BVD2_BATT,
    PCS_BVD2_SPKR,
    PCS_BVD2_LED
  } pcs_bvd2_e;

  typedef struct packed {
    logic      if_en;
    logic      pwr_on;
    logic      card_rst;
    logic      width16;
    pcs_mode_e mode;
  } pcs_ctrl_s;

  typedef struct packed {
    logic      spk_en;
    logic [1:0] rsvd;
    pcs_bvd2_e bvd2_fn;
  } pcs_misc_s;

  // synchronised socket pins, all as seen on the pin (active low kept)
  typedef struct packed {
    logic cd2;
    logic cd1;
    logic vs2;
    logic vs1;
    logic rdy;
    logic wait_n;
    logic bvd2;
    logic inpack;
  } pcs_pins_s;

endpackage : pcs_pkg

// File: verilog/pcs_socket_ctl.sv
// socket control and status signal logic for one card socket
// assumes socket pins are asynchronous; register port is on i_mclk
//
// Function
// [R1] 16-bit input acknowledge unused; in CardBus it is request input.
// [R2] memory mode: ready pin gives ready versus busy status.
// [R3] I/O mode: ready pin is a card interrupt request.
// [R4] CardBus: shared pin is active-low level interrupt.
// [R5] wait asserted holds the access cycle; resume after release.
// [R6] CardBus: wait pin is the system error input.
// [R7] two card detect inputs indicate card present.
// [R8] CardBus: detect plus voltage sense give presence and card type.
// [R9] card enables driven low; first even bytes, second odd bytes.
// [R10] 8-bit cards: only first enable, address bit zero picks byte.
// [R11] CardBus: second enable pin is address/data bit 10.
// [R12] CardBus: first enable pin is command/byte-enable lane zero.
// [R13] 16-bit: reset output low normally, high resets the card.
// [R14] reset pin floats unless card seated, powered and enabled.
// [R15] CardBus: reset pin is the active-low CardBus reset.
// [R16] memory mode: battery detect two is battery warning.
// [R17] I/O mode: battery detect two may be speaker input.
// [R18] disk cards: battery detect two may be activity LED input.
// [R19] CardBus: battery detect two is the audio input.
// [R20] speaker routed out only when misc bit 4 set.
// [R21] LED-programmed pin drives LED output showing disk activity.
// [R22] present when both detects low, after debounce.
// [R23] all card status inputs synchronised before use.
//
// The address map and the strobed register port were left to the implementer.
module pcs_socket_ctl
  import pcs_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // access request port
  input  wire logic        i_acc_req,
  input  wire logic        i_acc_a0,
  input  wire logic        i_acc_word,
  output logic             o_acc_busy,
  output logic             o_acc_done,
  // cardbus side data for shared enable pins
  input  wire logic        i_cb_cad10,
  input  wire logic        i_cb_cad10_oe,
  input  wire logic        i_cb_cbe0_n,
  input  wire logic        i_cb_cbe0_oe,
  output logic             o_cb_cad10,
  output logic             o_cb_cbe0_n,
  // socket pins
  input  wire logic        i_cd1_n,
  input  wire logic        i_cd2_n,
  input  wire logic        i_vs1,
  input  wire logic        i_vs2,
  input  wire logic        i_rdy_ireq,
  input  wire logic        i_wait_n,
  input  wire logic        i_bvd2,
  input  wire logic        i_inpack_creq_n,
  input  wire logic        i_ce1_pin,
  input  wire logic        i_ce2_pin,
  output logic             o_ce1,
  output logic             o_ce1_oe,
  output logic             o_ce2,
  output logic             o_ce2_oe,
  output logic             o_a0,
  output logic             o_card_rst,
  output logic             o_card_rst_oe,
  // status outputs
  output logic             o_card_present,
  output logic             o_card_irq,
  output logic             o_cb_req,
  output logic             o_cb_serr,
  output logic             o_spkr,
  output logic             o_led
);

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_STROBE,
    ACC_HOLD,
    ACC_DONE
  } pcs_acc_e;

  localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_CYC - 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEB_CYCLES - 1);

  // reset release
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // pin synchronisers
  pcs_pins_s pin_raw;
  pcs_pins_s pin_meta_ff;
  pcs_pins_s pin_ff;

  assign pin_raw = '{cd2: i_cd2_n, cd1: i_cd1_n, vs2: i_vs2, vs1: i_vs1,
                     rdy: i_rdy_ireq, wait_n: i_wait_n, bvd2: i_bvd2,
                     inpack: i_inpack_creq_n};

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= '1;
      pin_ff      <= '1;
    end else begin
      pin_meta_ff <= pin_raw; // R23
      pin_ff      <= pin_meta_ff; // R23
    end
  end

  // registers
  pcs_ctrl_s ctrl_ff;
  pcs_misc_s misc_ff;
  logic      chg_ff;
  logic      nxt_chg;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        hit_ctrl;
  logic        hit_misc;
  logic        hit_stat;
  logic [31:0] stat_word;

  assign hit_ctrl = (i_addr == CTRL_OFS);
  assign hit_misc = (i_addr == MISC_OFS);
  assign hit_stat = (i_addr == STAT_OFS);

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= pcs_ctrl_s'(CTRL_RESET_VAL);
      misc_ff <= pcs_misc_s'(MISC_RESET_VAL);
    end else if (i_wr && hit_ctrl) begin
      ctrl_ff <= pcs_ctrl_s'(i_wdata[5:0]);
    end else if (i_wr && hit_misc) begin
      misc_ff <= pcs_misc_s'(i_wdata[4:0]);
    end
  end

  // card detect debounce
  logic             both_low;
  logic             present_ff;
  logic [CNT_W-1:0] deb_cnt_ff;
  logic [CNT_W-1:0] nxt_deb_cnt;
  logic             deb_settled;
  logic [3:0]       type_ff;

  assign both_low    = !pin_ff.cd1 && !pin_ff.cd2; // R7 R22
  assign deb_settled = (deb_cnt_ff == DEB_LAST);
  assign nxt_deb_cnt = (both_low == present_ff) ? '0 :
                       deb_settled ? '0 : deb_cnt_ff + 1'b1; // R22

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      deb_cnt_ff <= '0;
      present_ff <= 1'b0;
      type_ff    <= 4'h0;
    end else begin
      deb_cnt_ff <= nxt_deb_cnt;
      if (both_low != present_ff && deb_settled) begin
        present_ff <= both_low; // R22
        type_ff    <= {pin_ff.cd2, pin_ff.cd1, pin_ff.vs2, pin_ff.vs1}; // R8
      end
    end
  end

  // insertion or removal flag: set wins over write-one clear
  logic present_edge;
  assign present_edge = (both_low != present_ff) && deb_settled;
  assign nxt_chg = present_edge ? 1'b1 :
                   (i_wr && hit_stat && i_wdata[STAT_CHG_BIT]) ? 1'b0 :
                   chg_ff;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      chg_ff <= 1'b0;
    end else begin
      chg_ff <= nxt_chg;
    end
  end

  // mode dependent pin meanings
  logic is_mem;
  logic is_io;
  logic is_cb;
  logic ready_st;
  logic irq_lvl;
  logic batt_warn;
  logic serr_lvl;
  logic creq_lvl;
  logic wait_act;
  logic spk_src;
  logic spk_route;
  logic led_lvl;

  assign is_mem    = (ctrl_ff.mode == PCS_MODE_MEM);
  assign is_io     = (ctrl_ff.mode == PCS_MODE_IO);
  assign is_cb     = (ctrl_ff.mode == PCS_MODE_CB);
  assign ready_st  = is_mem && pin_ff.rdy; // R2
  assign irq_lvl   = is_io ? !pin_ff.rdy : // R3
                     is_cb ? !pin_ff.rdy : 1'b0; // R4
  assign batt_warn = is_mem && !pin_ff.bvd2; // R16
  assign serr_lvl  = is_cb && !pin_ff.wait_n; // R6
  assign creq_lvl  = is_cb && !pin_ff.inpack; // R1
  assign wait_act  = !is_cb && !pin_ff.wait_n; // R5
  assign spk_src   = is_cb ? pin_ff.bvd2 : // R19
                     (is_io && misc_ff.bvd2_fn == PCS_BVD2_SPKR) ?
                     !pin_ff.bvd2 : 1'b0; // R17
  assign spk_route = misc_ff.spk_en && spk_src; // R20
  assign led_lvl   = !is_cb && misc_ff.bvd2_fn == PCS_BVD2_LED &&
                     !pin_ff.bvd2; // R18 R21

  // access sequencer
  pcs_acc_e         acc_st_ff;
  pcs_acc_e         nxt_acc_st;
  logic [CNT_W-1:0] acc_cnt_ff;
  logic [CNT_W-1:0] nxt_acc_cnt;
  logic             acc_take;
  logic             word_ff;
  logic             a0_ff;

  assign acc_take = i_acc_req && (acc_st_ff == ACC_IDLE) && !is_cb &&
                    present_ff && ctrl_ff.if_en;

  always_comb begin
    nxt_acc_st  = acc_st_ff;
    nxt_acc_cnt = acc_cnt_ff;
    case (acc_st_ff)
      ACC_IDLE: begin
        nxt_acc_cnt = '0;
        if (acc_take) begin
          nxt_acc_st = ACC_STROBE;
        end
      end
      ACC_STROBE: begin
        nxt_acc_cnt = acc_cnt_ff + 1'b1;
        if (acc_cnt_ff == CMD_LAST) begin
          nxt_acc_st = ACC_HOLD;
        end
      end
      ACC_HOLD: begin
        if (!wait_act) begin // R5
          nxt_acc_st = ACC_DONE;
        end
      end
      default: begin
        nxt_acc_st = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_st_ff  <= ACC_IDLE;
      acc_cnt_ff <= '0;
      word_ff    <= 1'b0;
      a0_ff      <= 1'b0;
    end else begin
      acc_st_ff  <= nxt_acc_st;
      acc_cnt_ff <= nxt_acc_cnt;
      if (acc_take) begin
        word_ff <= i_acc_word;
        a0_ff   <= i_acc_a0;
      end
    end
  end

  // card enables
  logic in_cycle;
  logic nxt_ce1;
  logic nxt_ce2;
  logic nxt_ce1_oe;
  logic nxt_ce2_oe;
  logic nxt_a0;
  logic acc_word;
  logic acc_a0;

  assign in_cycle = (nxt_acc_st == ACC_STROBE) || (nxt_acc_st == ACC_HOLD);
  assign acc_word = acc_take ? i_acc_word : word_ff;
  assign acc_a0   = acc_take ? i_acc_a0 : a0_ff;
  assign nxt_ce1 = is_cb ? i_cb_cbe0_n : // R12
                   !(in_cycle && (!ctrl_ff.width16 || acc_word || !acc_a0));
                   // R9 R10
  assign nxt_ce2 = is_cb ? i_cb_cad10 : // R11
                   !(in_cycle && ctrl_ff.width16 && (acc_word || acc_a0));
                   // R9 R10
  assign nxt_ce1_oe = is_cb ? i_cb_cbe0_oe : ctrl_ff.if_en;
  assign nxt_ce2_oe = is_cb ? i_cb_cad10_oe : ctrl_ff.if_en;
  assign nxt_a0  = in_cycle && !ctrl_ff.width16 && acc_a0; // R10

  // card reset pin
  logic nxt_rst;
  logic nxt_rst_oe;
  assign nxt_rst    = is_cb ? !ctrl_ff.card_rst : // R15
                      ctrl_ff.card_rst; // R13
  assign nxt_rst_oe = present_ff && ctrl_ff.pwr_on && ctrl_ff.if_en; // R14

  // status word and read data
  assign stat_word = {19'h0_0000, chg_ff, type_ff,
                      (acc_st_ff != ACC_IDLE), wait_act, creq_lvl,
                      serr_lvl, batt_warn, irq_lvl, ready_st, present_ff};
  assign nxt_rdata = !i_rd ? 32'h0000_0000 :
                     hit_ctrl ? {26'h000_0000, ctrl_ff} :
                     hit_misc ? {27'h000_0000, misc_ff} :
                     hit_stat ? stat_word : 32'h0000_0000;

  // output registers
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff       <= 32'h0000_0000;
      o_acc_busy     <= 1'b0;
      o_acc_done     <= 1'b0;
      o_ce1          <= 1'b1;
      o_ce2          <= 1'b1;
      o_ce1_oe       <= 1'b0;
      o_ce2_oe       <= 1'b0;
      o_a0           <= 1'b0;
      o_cb_cad10     <= 1'b0;
      o_cb_cbe0_n    <= 1'b1;
      o_card_rst     <= 1'b0;
      o_card_rst_oe  <= 1'b0;
      o_card_present <= 1'b0;
      o_card_irq     <= 1'b0;
      o_cb_req       <= 1'b0;
      o_cb_serr      <= 1'b0;
      o_spkr         <= 1'b0;
      o_led          <= 1'b0;
    end else begin
      rdata_ff       <= nxt_rdata;
      o_acc_busy     <= (nxt_acc_st != ACC_IDLE);
      o_acc_done     <= (nxt_acc_st == ACC_DONE);
      o_ce1          <= nxt_ce1;
      o_ce2          <= nxt_ce2;
      o_ce1_oe       <= nxt_ce1_oe;
      o_ce2_oe       <= nxt_ce2_oe;
      o_a0           <= nxt_a0;
      o_cb_cad10     <= i_ce2_pin;
      o_cb_cbe0_n    <= i_ce1_pin;
      o_card_rst     <= nxt_rst;
      o_card_rst_oe  <= nxt_rst_oe;
      o_card_present <= present_ff;
      o_card_irq     <= irq_lvl;
      o_cb_req       <= creq_lvl;
      o_cb_serr      <= serr_lvl;
      o_spkr         <= spk_route;
      o_led          <= led_lvl;
    end
  end
  assign o_rdata = rdata_ff;

endmodule // pcs_socket_ctl
